// file: design/relative_subroutine_call_reset_decoder.sv
// module: relative subroutine call and soft reset execution
`timescale 1ns/1ps
module relative_subroutine_call_reset_decoder
    import relative_subroutine_call_reset_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire fetch_t i_fetch,
    output logic [1:0] o_phase,
    output stack_push_t o_push,
    output pc_write_t o_pc_wr,
    output logic o_soft_reset,
    output logic o_busy,
    output logic o_flags_untouched
);
    typedef enum logic [1:0] {S_IDLE, S_CALL, S_NOP} state_t;

    state_t state_q;
    logic [1:0] phase;
    logic [15:0] word_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] ret_q;
    logic reset_pend_q;
    logic take_call;
    logic take_reset;

    // the offset must sit directly below the opcode and leave room for the doubling
    if (PC_W <= OFS_W + 1) begin : g_pc_width_check
        $error("program counter too narrow for the call offset");
    end
    if (CALL_OP_LSB != OFS_W) begin : g_opcode_check
        $error("call opcode must sit directly above the offset field");
    end

    function automatic logic is_call(input logic [15:0] w);
        return w[15:CALL_OP_LSB] == CALL_OP;
    endfunction

    function automatic logic [PC_W-1:0] call_target(input logic [PC_W-1:0] ret,
                                                     input logic [OFS_W-1:0] n);
        logic [PC_W-1:0] ofs;
        ofs = {{(PC_W-OFS_W){n[OFS_W-1]}}, n};
        return ret + {ofs[PC_W-2:0], 1'b0};
    endfunction

    quarter_counter u_quarter (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .o_phase(phase)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_phase <= Q_RESET;
        end else begin
            o_phase <= phase;
        end
    end

    // a word is taken only in Q1 while idle; anything offered during a call is dropped
    assign take_call = state_q == S_IDLE && phase == Q1 && i_fetch.valid
                       && is_call(i_fetch.word);
    assign take_reset = state_q == S_IDLE && phase == Q1 && i_fetch.valid
                        && i_fetch.word == SOFT_RESET_OP;

    // instruction sequencing; an instruction is taken in Q1
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= S_IDLE;
            word_q <= 16'h0000;
            pc_q <= PC_RESET;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (take_call) begin
                        state_q <= S_CALL;
                        word_q <= i_fetch.word;
                        pc_q <= i_fetch.pc;
                    end
                end
                S_CALL: begin
                    if (phase == Q4) begin
                        state_q <= S_NOP;
                    end
                end
                S_NOP: begin
                    if (phase == Q4) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // push in Q2 of the first cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_push <= '0;
            ret_q <= PC_RESET;
        end else begin
            o_push.push <= 1'b0;
            if (state_q == S_CALL && phase == Q2) begin
                o_push.push <= 1'b1;
                o_push.ret_addr <= pc_q + PC_STEP;
                ret_q <= pc_q + PC_STEP;
            end
        end
    end

    // program counter written in Q4 of the first cycle, after the push
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pc_wr <= '0;
        end else begin
            o_pc_wr.load <= 1'b0;
            if (state_q == S_CALL && phase == Q4) begin
                o_pc_wr.load <= 1'b1;
                o_pc_wr.target <= call_target(ret_q, word_q[OFS_W-1:0]);
            end
        end
    end

    // soft reset decoded in Q1 and held one clock, so that the pulse shares Q2 with o_phase
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            reset_pend_q <= 1'b0;
        end else begin
            reset_pend_q <= take_reset;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= reset_pend_q && phase == Q2;
        end
    end

    // busy covers all eight clocks of a call, from the clock after the take
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
            o_flags_untouched <= 1'b1;
        end else begin
            o_busy <= state_q != S_IDLE || take_call;
            o_flags_untouched <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // every output is registered one clock after its decision and o_phase is delayed to match,
    // so the checks read each pulse against the quarter phase it shares on the pins

    property push_after_take_p;
        take_call |-> ##2 (o_push.push && o_push.ret_addr == $past(i_fetch.pc, 2) + PC_STEP);
    endproperty
    call_push_a: assert property (push_after_take_p)
        else $error("return address not pushed as pc plus 2");

    call_target_a: assert property (o_pc_wr.load |-> o_pc_wr.target ==
            pc_q + PC_STEP + {{(PC_W-OFS_W-1){word_q[OFS_W-1]}}, word_q[OFS_W-1:0], 1'b0})
        else $error("call target wrong");

    push_before_pc_a: assert property (o_push.push |-> ##2 o_pc_wr.load)
        else $error("pc not written two clocks after push");

    target_range_a: assert property (o_pc_wr.load |->
            ($signed(o_pc_wr.target - ret_q) >= -2048 && $signed(o_pc_wr.target - ret_q) <= 2046))
        else $error("call target out of range");

    call_length_a: assert property ($rose(o_busy) |->
            o_busy [*8] ##1 (o_busy == $past(take_call)))
        else $error("call not two instruction cycles");

    push_phase_a: assert property (o_push.push |-> o_phase == Q2)
        else $error("push outside Q2");

    load_phase_a: assert property (o_pc_wr.load |-> o_phase == Q4)
        else $error("pc write outside Q4");

    nop_cycle_a: assert property (o_pc_wr.load |=>
            (!o_push.push && !o_pc_wr.load && !o_soft_reset) [*4])
        else $error("second call cycle not idle");

    push_once_a: assert property (o_push.push |=> !o_push.push [*7])
        else $error("more than one push per call");

    load_needs_push_a: assert property (o_pc_wr.load |-> $past(o_push.push, 2))
        else $error("pc written without a push");

    busy_span_a: assert property ((o_push.push || o_pc_wr.load) |-> o_busy)
        else $error("call output outside busy");

    word_hold_a: assert property (state_q != S_IDLE |=> $stable(word_q) && $stable(pc_q))
        else $error("word taken during a call");

    phase_wrap_a: assert property (o_phase == Q4 |=> o_phase == Q1)
        else $error("quarter phase out of order");

    reset_pulse_a: assert property (o_soft_reset |-> o_phase == Q2 ##1 !o_soft_reset)
        else $error("soft reset not a single Q2 pulse");

    reset_decode_a: assert property (take_reset |-> ##2 o_soft_reset)
        else $error("soft reset not decoded");

    reset_alone_a: assert property (o_soft_reset |->
            !o_push.push && !o_pc_wr.load && !o_busy)
        else $error("soft reset overlaps a call");

    flags_kept_a: assert property (o_flags_untouched)
        else $error("flags touched");

    call_seen_c: cover property (o_pc_wr.load);
    back_call_c: cover property (o_pc_wr.load && word_q[OFS_W-1]);
    fwd_call_c: cover property (o_pc_wr.load && !word_q[OFS_W-1]);
    soft_reset_c: cover property (o_soft_reset);
    refused_c: cover property (o_busy && i_fetch.valid && phase == Q1);
endmodule // relative_subroutine_call_reset_decoder

// file: design/relative_subroutine_call_reset_pkg.sv
// package: constants and carrier types for the relative call and soft reset decoder
package relative_subroutine_call_reset_pkg;
    localparam int PC_W = 21;
    localparam int OFS_W = 11;
    localparam logic [4:0] CALL_OP = 5'h1B;
    localparam int CALL_OP_LSB = 11;
    localparam logic [15:0] SOFT_RESET_OP = 16'h00FF;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [1:0] Q_RESET = 2'h0;
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
        logic [PC_W-1:0] pc;
    } fetch_t;

    typedef struct packed {
        logic push;
        logic [PC_W-1:0] ret_addr;
    } stack_push_t;

    typedef struct packed {
        logic load;
        logic [PC_W-1:0] target;
    } pc_write_t;
endpackage

// file: design/quarter_counter.sv
// module: quarter-cycle phase counter, four phases per instruction cycle
`timescale 1ns/1ps
module quarter_counter
    import relative_subroutine_call_reset_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    output logic [1:0] o_phase
);
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_phase <= Q_RESET;
        end else begin
            o_phase <= o_phase + 2'h1;
        end
    end
endmodule // quarter_counter

// file: tb/relative_call_and_soft_reset_tb_top.sv
// testbench: relative call and soft reset decoder
`timescale 1ns/1ps
module relative_call_and_soft_reset_tb_top;
    import relative_subroutine_call_reset_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    fetch_t fetch = '0;
    logic [1:0] o_phase;
    stack_push_t o_push;
    pc_write_t o_pc_wr;
    logic o_soft_reset;
    logic o_busy;
    logic o_flags_untouched;
    int n_mismatch = 0;
    int cmp_count = 0;

    relative_subroutine_call_reset_decoder DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_fetch(fetch),
        .o_phase(o_phase), .o_push(o_push), .o_pc_wr(o_pc_wr),
        .o_soft_reset(o_soft_reset), .o_busy(o_busy),
        .o_flags_untouched(o_flags_untouched));

    always #5 i_clk = ~i_clk;

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // presents one word for the Q1 take edge, then drops valid
    task automatic issue(input logic [15:0] w, input logic [PC_W-1:0] pc);
        int g;
        g = 0;
        do begin
            @(negedge i_clk);
            g++;
        end while (o_phase !== 2'h3 && g < 9);
        fetch = '{valid: 1'b1, word: w, pc: pc};
        @(negedge i_clk);
        fetch.valid = 1'b0;
    endtask

    task automatic do_call(input logic [PC_W-1:0] pc, input logic [10:0] n,
                           input logic [PC_W-1:0] tgt);
        issue({CALL_OP, n}, pc);
        chk(o_busy === 1'b1, "busy start");
        for (int k = 1; k < 10; k++) begin
            @(negedge i_clk);
            chk(o_push.push === (k == 1), "push timing");
            if (k == 1) chk(o_push.ret_addr === pc + 21'h000002, "return addr");
            chk(o_pc_wr.load === (k == 3), "pc load timing");
            if (k == 3) chk(o_pc_wr.target === tgt, "call target");
            chk(o_busy === (k < 8), "busy span");
            chk(o_soft_reset === 1'b0, "stray soft reset");
            chk(o_flags_untouched === 1'b1, "flags touched");
        end
    endtask

    // a soft reset word offered in the call's second cycle must be ignored
    task automatic do_refused();
        issue({CALL_OP, 11'h005}, 21'h000200);
        repeat (3) @(negedge i_clk);
        fetch = '{valid: 1'b1, word: SOFT_RESET_OP, pc: 21'h000300};
        for (int k = 4; k < 12; k++) begin
            @(negedge i_clk);
            if (k == 6) fetch.valid = 1'b0;
            chk(o_push.push === 1'b0 && o_soft_reset === 1'b0, "word taken while busy");
        end
    endtask

    task automatic do_reset_op(input logic [15:0] w, input logic hit);
        issue(w, 21'h000040);
        @(negedge i_clk);
        chk(o_soft_reset === hit, "soft reset pulse");
        if (hit) chk(o_phase === Q2, "soft reset phase");
        chk((o_push.push | o_pc_wr.load | o_busy) === 1'b0, "stray call");
        @(negedge i_clk);
        chk(o_soft_reset === 1'b0, "soft reset width");
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge i_clk);
        i_rstn = 1'b1;
        do_call(21'h000100, 11'h3FF, 21'h000900);
        do_call(21'h000800, 11'h400, 21'h000002);
        do_call(21'h000000, 11'h400, 21'h1FF802);
        do_call(21'h012344, 11'h001, 21'h012348);
        do_refused();
        do_reset_op(16'h00FF, 1'b1);
        do_reset_op(16'h00FF, 1'b1);
        do_reset_op(16'h01FF, 1'b0);
        do_reset_op(16'h00FE, 1'b0);
        wrap_up();
    end

    // whole run is well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end
endmodule // relative_call_and_soft_reset_tb_top
